// >>> verilog/mps_regs.sv
// Summary of operation
// R1: Left mute bit ramps left volume smoothly to silence and back.
// R2: Right mute bit ramps right volume smoothly to silence and back.
// R3: Status bit 7 mirrors the live backend frame strobe.
// R4: Bit 6 high only when both regulator power-on resets are detected.
// R5: Bit 5 high when analog and pump supplies good and amps unmuted.
// R6: PLL lock flag reads 0 locked, 1 unlocked; resets to 0.
// R7: With PLL disabled the lock flag always reads 1.
// R8: PLL enable resets to 1; clearing selects external master clock.
// R9: Oscillator-selected bit set while internal oscillator clocks the system.
// R10: Oscillator-off bit set when auto-off and oscillator unused.
// R11: Auto-off bit resets to 1; 0 keeps oscillator always running.
// R12: Clock error forces the same standby as the standby request bit.
// R13: Software writes reserved bits as zero; read-only bits ignore writes.
`default_nettype none
module mps_regs
    import mps_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Host register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    output logic [7:0] REG_RDATA_O,
    // Backend and supply status
    input wire logic FRAME_STROBE_I,
    input wire logic LDO_IN_POR_I,
    input wire logic LDO_OUT_POR_I,
    input wire logic ANALOG_SUPPLY_POR_I,
    input wire logic CHARGE_PUMP_SUPPLY_POR_I,
    input wire logic LINE_AMP_UNMUTED_I,
    // Clocking status
    input wire logic PLL_LOCKED_I,
    input wire logic CLOCK_ERROR_I,
    input wire logic OSC_NEEDED_I,
    input wire logic STANDBY_REQUEST_I,
    // Controls out
    output logic [MPS_VOL_W-1:0] LEFT_VOLUME_O,
    output logic [MPS_VOL_W-1:0] RIGHT_VOLUME_O,
    output logic LEFT_SILENT_O,
    output logic RIGHT_SILENT_O,
    output logic PLL_ON_O,
    output logic EXT_MCLK_SEL_O,
    output logic OSC_SELECTED_O,
    output logic OSC_POWER_DOWN_O,
    output logic BACKEND_BUFFER_OE_O,
    output logic SYSTEM_STANDBY_O
);
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic left_soft_mute_request_q;
    logic right_soft_mute_request_q;
    logic pll_on_q;
    logic osc_auto_off_q;
    logic pll_unlocked_flag_q;
    logic osc_emergency_selected_q;
    logic osc_off_status_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Any other address matches none of these, so its write is dropped
    wire logic wr_mute = REG_WR_I && (REG_ADDR_I == MPS_MUTE_STATUS_OFS);
    wire logic wr_pll = REG_WR_I && (REG_ADDR_I == MPS_PLL_CTRL_OFS);
    wire logic wr_osc = REG_WR_I && (REG_ADDR_I == MPS_OSC_CTRL_OFS);

    // Only writable fields are stored; reserved and status bits drop
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            left_soft_mute_request_q <= MPS_MUTE_RST;
            right_soft_mute_request_q <= MPS_MUTE_RST;
            pll_on_q <= MPS_PLL_ON_RST; // [R8]
            osc_auto_off_q <= MPS_OSC_AUTO_OFF_RST; // [R11]
        end
        else
        begin
            if (wr_mute)
            begin
                left_soft_mute_request_q <=
                    REG_WDATA_I[MPS_LEFT_MUTE_BIT]; // [R1] [R13]
                right_soft_mute_request_q <=
                    REG_WDATA_I[MPS_RIGHT_MUTE_BIT]; // [R2] [R13]
            end
            if (wr_pll)
                pll_on_q <= REG_WDATA_I[MPS_PLL_ON_BIT]; // [R8]
            if (wr_osc)
                osc_auto_off_q <= REG_WDATA_I[MPS_OSC_AUTO_OFF_BIT]; // [R11]
        end
    end

    // ----------------------------------------
    // Clock source status
    // ----------------------------------------
    // Disabled PLL overrides any lock indication
    wire logic unlocked_d = !pll_on_q || !PLL_LOCKED_I; // [R6] [R7]
    // Clock error means the normal clock cannot be trusted
    wire logic osc_sel_d = CLOCK_ERROR_I; // [R9]
    wire logic osc_off_d = osc_auto_off_q && !osc_sel_d
                        && !OSC_NEEDED_I; // [R10] [R11]

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            // Quiet state until the first sampled status
            pll_unlocked_flag_q <= MPS_PLL_UNLOCKED_RST; // [R6]
            osc_emergency_selected_q <= MPS_OSC_SEL_RST;
            osc_off_status_q <= MPS_OSC_OFF_RST;
        end
        else
        begin
            pll_unlocked_flag_q <= unlocked_d; // [R6] [R7]
            osc_emergency_selected_q <= osc_sel_d; // [R9]
            osc_off_status_q <= osc_off_d; // [R10]
        end
    end

    // ----------------------------------------
    // Backend status
    // ----------------------------------------
    // Live levels, not latched: they drop as soon as a supply drops
    wire logic backend_buffer_drive_status =
        LDO_IN_POR_I && LDO_OUT_POR_I; // [R4]
    wire logic backend_powered_status = ANALOG_SUPPLY_POR_I
        && CHARGE_PUMP_SUPPLY_POR_I && LINE_AMP_UNMUTED_I; // [R5]

    // ----------------------------------------
    // Soft-mute ramps
    // ----------------------------------------
    // One divider feeds both channels so their steps stay aligned
    logic [MPS_DIV_W-1:0] div_q;
    wire logic step_en = (div_q == MPS_DIV_ZERO);

    // Slow step keeps each level change inaudible
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            div_q <= MPS_RAMP_STEP_CYC;
        else if (step_en)
            div_q <= MPS_RAMP_STEP_CYC;
        else
            div_q <= div_q - MPS_DIV_ONE;
    end

    logic [MPS_CHANNELS-1:0] mute_req;
    logic [MPS_CHANNELS-1:0] silent;
    logic [MPS_VOL_W-1:0] level [MPS_CHANNELS];
    assign mute_req = {left_soft_mute_request_q, right_soft_mute_request_q};

    // Channel 0 is right, channel 1 is left
    for (genvar ch = 0; ch < MPS_CHANNELS; ch++)
    begin : g_ramp
        mps_ramp_if rif ();
        assign rif.step_en = step_en;
        assign rif.mute_req = mute_req[ch]; // [R1] [R2]
        assign level[ch] = rif.level;
        assign silent[ch] = rif.silent;
        mps_ramp u_ramp (
            .clk_i(CLK_I),
            .reset_n_i(RESET_N_I),
            .rif(rif.ramp)
        );
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Reserved bits always read as zero whatever was written
    logic [7:0] mute_rd;
    logic [7:0] pll_rd;
    logic [7:0] osc_rd;

    always_comb
    begin
        mute_rd = MPS_ZERO_BYTE;
        mute_rd[MPS_FRAME_STROBE_BIT] = FRAME_STROBE_I; // [R3]
        mute_rd[MPS_BUF_DRIVE_BIT] = backend_buffer_drive_status; // [R4]
        mute_rd[MPS_BACKEND_PWR_BIT] = backend_powered_status; // [R5]
        mute_rd[MPS_LEFT_MUTE_BIT] = left_soft_mute_request_q; // [R1]
        mute_rd[MPS_RIGHT_MUTE_BIT] = right_soft_mute_request_q; // [R2]
        pll_rd = MPS_ZERO_BYTE;
        pll_rd[MPS_PLL_UNLOCKED_BIT] = pll_unlocked_flag_q; // [R6]
        pll_rd[MPS_PLL_ON_BIT] = pll_on_q; // [R8]
        osc_rd = MPS_ZERO_BYTE;
        osc_rd[MPS_OSC_SELECTED_BIT] = osc_emergency_selected_q; // [R9]
        osc_rd[MPS_OSC_OFF_BIT] = osc_off_status_q; // [R10]
        osc_rd[MPS_OSC_AUTO_OFF_BIT] = osc_auto_off_q; // [R11]
    end

    // Addresses outside the bank read as zero
    assign rdata_d = (REG_ADDR_I == MPS_MUTE_STATUS_OFS) ? mute_rd
                   : (REG_ADDR_I == MPS_PLL_CTRL_OFS) ? pll_rd
                   : (REG_ADDR_I == MPS_OSC_CTRL_OFS) ? osc_rd
                   : MPS_ZERO_BYTE;

    // Registered: valid one edge after the address settles
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            rdata_q <= MPS_ZERO_BYTE;
        else
            rdata_q <= rdata_d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign REG_RDATA_O = rdata_q;
    assign LEFT_VOLUME_O = level[1];
    assign RIGHT_VOLUME_O = level[0];
    assign LEFT_SILENT_O = silent[1];
    assign RIGHT_SILENT_O = silent[0];
    assign PLL_ON_O = pll_on_q; // [R8]
    assign EXT_MCLK_SEL_O = !pll_on_q; // [R8]
    assign OSC_SELECTED_O = osc_emergency_selected_q; // [R9]
    assign OSC_POWER_DOWN_O = osc_off_status_q; // [R10]
    assign BACKEND_BUFFER_OE_O = backend_buffer_drive_status; // [R4]
    // No latency: a clock error must reach standby at once
    assign SYSTEM_STANDBY_O = STANDBY_REQUEST_I || CLOCK_ERROR_I; // [R12]
endmodule
`default_nettype wire

// >>> verilog/mps_pkg.sv
`default_nettype none
package mps_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] MPS_MUTE_STATUS_OFS = 8'h03;
    localparam logic [7:0] MPS_PLL_CTRL_OFS = 8'h04;
    localparam logic [7:0] MPS_OSC_CTRL_OFS = 8'h05;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MPS_FRAME_STROBE_BIT = 7;
    localparam int MPS_BUF_DRIVE_BIT = 6;
    localparam int MPS_BACKEND_PWR_BIT = 5;
    localparam int MPS_LEFT_MUTE_BIT = 4;
    localparam int MPS_RIGHT_MUTE_BIT = 0;
    localparam int MPS_PLL_UNLOCKED_BIT = 4;
    localparam int MPS_PLL_ON_BIT = 0;
    localparam int MPS_OSC_SELECTED_BIT = 5;
    localparam int MPS_OSC_OFF_BIT = 4;
    localparam int MPS_OSC_AUTO_OFF_BIT = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic MPS_MUTE_RST = 1'b0;
    localparam logic MPS_PLL_UNLOCKED_RST = 1'b0;
    localparam logic MPS_PLL_ON_RST = 1'b1;
    localparam logic MPS_OSC_AUTO_OFF_RST = 1'b1;
    localparam logic MPS_OSC_SEL_RST = 1'b0;
    localparam logic MPS_OSC_OFF_RST = 1'b0;
    localparam logic [7:0] MPS_ZERO_BYTE = 8'h00;

    // ----------------------------------------
    // Volume ramp
    // ----------------------------------------
    localparam int MPS_VOL_W = 8;
    localparam logic [MPS_VOL_W-1:0] MPS_VOL_FULL = 8'hFF;
    localparam logic [MPS_VOL_W-1:0] MPS_VOL_SILENT = 8'h00;
    localparam logic [MPS_VOL_W-1:0] MPS_VOL_STEP = 8'h01;
    localparam int MPS_CLK_MHZ = 50;
    localparam int MPS_RAMP_STEP_NS = 20000;
    localparam int MPS_RAMP_STEP_CYC_INT =
        (MPS_RAMP_STEP_NS * MPS_CLK_MHZ) / 1000;
    localparam int MPS_DIV_W = 10;
    localparam logic [MPS_DIV_W-1:0] MPS_RAMP_STEP_CYC =
        MPS_DIV_W'(MPS_RAMP_STEP_CYC_INT - 1);
    localparam logic [MPS_DIV_W-1:0] MPS_DIV_ZERO = 10'h000;
    localparam logic [MPS_DIV_W-1:0] MPS_DIV_ONE = 10'h001;
    localparam int MPS_CHANNELS = 2;
endpackage
`default_nettype wire

// >>> verilog/mps_ramp_if.sv
`default_nettype none
interface mps_ramp_if;
    import mps_pkg::*;
    logic step_en;
    logic mute_req;
    logic [MPS_VOL_W-1:0] level;
    logic silent;

    modport ctrl (output step_en, output mute_req,
                  input level, input silent);
    modport ramp (input step_en, input mute_req,
                  output level, output silent);
endinterface
`default_nettype wire

// >>> verilog/mps_ramp.sv
`default_nettype none
module mps_ramp
    import mps_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Ramp control
    mps_ramp_if.ramp rif
);
    logic [MPS_VOL_W-1:0] level_q;
    logic [MPS_VOL_W-1:0] level_d;
    wire logic at_full = (level_q == MPS_VOL_FULL);
    wire logic at_silent = (level_q == MPS_VOL_SILENT);

    // One step per enable, so the level never jumps
    assign level_d = !rif.step_en ? level_q
                   : (rif.mute_req && !at_silent) ? level_q - MPS_VOL_STEP
                   : (!rif.mute_req && !at_full) ? level_q + MPS_VOL_STEP
                   : level_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            level_q <= MPS_VOL_FULL;
        else
            level_q <= level_d;
    end

    assign rif.level = level_q;
    assign rif.silent = at_silent;
endmodule
`default_nettype wire

// >>> dv/mps_regs_chk.sv
`default_nettype none
module mps_regs_chk (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Host port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_RDATA_O,
    // Status inputs
    input wire logic FRAME_STROBE_I,
    input wire logic LDO_IN_POR_I,
    input wire logic LDO_OUT_POR_I,
    input wire logic CLOCK_ERROR_I,
    input wire logic OSC_NEEDED_I,
    input wire logic STANDBY_REQUEST_I,
    // Outputs watched
    input wire logic [7:0] LEFT_VOLUME_O,
    input wire logic [7:0] RIGHT_VOLUME_O,
    input wire logic LEFT_SILENT_O,
    input wire logic RIGHT_SILENT_O,
    input wire logic PLL_ON_O,
    input wire logic EXT_MCLK_SEL_O,
    input wire logic OSC_SELECTED_O,
    input wire logic OSC_POWER_DOWN_O,
    input wire logic BACKEND_BUFFER_OE_O,
    input wire logic SYSTEM_STANDBY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Flag lags the enable by one edge, read data by one more
    sequence s_off_read;
        REG_ADDR_I == 8'h04 && !PLL_ON_O ##1 REG_ADDR_I == 8'h04;
    endsequence
    a_off_reads_unlocked: assert property (
        s_off_read |=> REG_RDATA_O[4])
        else $error("lock flag clear with pll off");
    a_left_ramp_step: assert property ($changed(LEFT_VOLUME_O) |->
        8'(LEFT_VOLUME_O - $past(LEFT_VOLUME_O)) inside {8'h01, 8'hFF})
        else $error("left volume jumped");
    a_right_ramp_hold: assert property ($changed(RIGHT_VOLUME_O) |=>
        $stable(RIGHT_VOLUME_O)[*8])
        else $error("right volume not held between steps");
    a_ext_clock_sel: assert property (EXT_MCLK_SEL_O == !PLL_ON_O)
        else $error("clock source not opposite of pll enable");
    a_pll_clear_off: assert property (
        REG_WR_I && REG_ADDR_I == 8'h04 && !REG_WDATA_I[0] |=> !PLL_ON_O)
        else $error("pll stays on after clear");
    a_osc_used_on: assert property (CLOCK_ERROR_I || OSC_NEEDED_I
        |=> !OSC_POWER_DOWN_O)
        else $error("oscillator off while in use");
    a_osc_sel_err: assert property (1'b1 |=>
        OSC_SELECTED_O == $past(CLOCK_ERROR_I))
        else $error("oscillator select not following clock error");
    a_buf_drive_por: assert property (BACKEND_BUFFER_OE_O ==
        (LDO_IN_POR_I && LDO_OUT_POR_I))
        else $error("buffer drive wrong");
    a_err_standby: assert property (SYSTEM_STANDBY_O ==
        (STANDBY_REQUEST_I || CLOCK_ERROR_I))
        else $error("standby wrong");
    a_unmapped_zero: assert property (
        !(REG_ADDR_I inside {[8'h03:8'h05]}) |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    a_silent_at_zero: assert property (
        LEFT_SILENT_O == (LEFT_VOLUME_O == 8'h00) &&
        RIGHT_SILENT_O == (RIGHT_VOLUME_O == 8'h00))
        else $error("silent flag does not match volume");
    a_strobe_read: assert property (REG_ADDR_I == 8'h03 |=>
        REG_RDATA_O[7] == $past(FRAME_STROBE_I))
        else $error("frame strobe not shown");
endmodule
bind mps_regs mps_regs_chk chk_u (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RDATA_O(REG_RDATA_O),
    .FRAME_STROBE_I(FRAME_STROBE_I), .LDO_IN_POR_I(LDO_IN_POR_I),
    .LDO_OUT_POR_I(LDO_OUT_POR_I), .CLOCK_ERROR_I(CLOCK_ERROR_I),
    .OSC_NEEDED_I(OSC_NEEDED_I), .STANDBY_REQUEST_I(STANDBY_REQUEST_I),
    .LEFT_VOLUME_O(LEFT_VOLUME_O), .RIGHT_VOLUME_O(RIGHT_VOLUME_O),
    .LEFT_SILENT_O(LEFT_SILENT_O), .RIGHT_SILENT_O(RIGHT_SILENT_O),
    .PLL_ON_O(PLL_ON_O), .EXT_MCLK_SEL_O(EXT_MCLK_SEL_O),
    .OSC_SELECTED_O(OSC_SELECTED_O), .OSC_POWER_DOWN_O(OSC_POWER_DOWN_O),
    .BACKEND_BUFFER_OE_O(BACKEND_BUFFER_OE_O),
    .SYSTEM_STANDBY_O(SYSTEM_STANDBY_O)
);
`default_nettype wire

// >>> dv/mps_regs_tb.sv
`default_nettype none
module mps_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, fs, ldi, ldo, av, cp, la, lk, ce, ond, sb;
    logic [7:0] addr, wdata, rdata, lvol, rvol;
    logic pll_on, ext, stby, lsil, rsil;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    mps_regs dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RDATA_O(rdata),
        .FRAME_STROBE_I(fs), .LDO_IN_POR_I(ldi), .LDO_OUT_POR_I(ldo),
        .ANALOG_SUPPLY_POR_I(av), .CHARGE_PUMP_SUPPLY_POR_I(cp),
        .LINE_AMP_UNMUTED_I(la), .PLL_LOCKED_I(lk), .CLOCK_ERROR_I(ce),
        .OSC_NEEDED_I(ond), .STANDBY_REQUEST_I(sb), .LEFT_VOLUME_O(lvol),
        .RIGHT_VOLUME_O(rvol), .LEFT_SILENT_O(lsil), .RIGHT_SILENT_O(rsil),
        .PLL_ON_O(pll_on), .EXT_MCLK_SEL_O(ext), .OSC_SELECTED_O(),
        .OSC_POWER_DOWN_O(), .BACKEND_BUFFER_OE_O(), .SYSTEM_STANDBY_O(stby));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Ceiling well above the longest ramp wait
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 50000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, exp);
        @(negedge clk);
        addr = a;
        repeat (2) @(negedge clk);
        chk(nm, rdata, exp);
    endtask
    task automatic t_status;
        {fs, ldi, ldo, av, cp, la} = 6'h3F;
        rd_chk("st_all", 8'h03, 8'hE0);
        la = 1'b0;
        rd_chk("st_amp_muted", 8'h03, 8'hC0);
        ldo = 1'b0;
        rd_chk("st_ldo_out", 8'h03, 8'h80);
        {fs, ldi, av, cp} = 4'h0;
        rd_chk("st_none", 8'h03, 8'h00);
    endtask
    task automatic t_pll;
        lk = 1'b0;
        rd_chk("pll_unlock", 8'h04, 8'h11);
        lk = 1'b1;
        wr_reg(8'h04, 8'hEE);
        rd_chk("pll_off", 8'h04, 8'h10);
        chk("ext_sel", {7'h00, ext}, 8'h01);
        wr_reg(8'h04, 8'h01);
        rd_chk("pll_on", 8'h04, 8'h01);
    endtask
    task automatic t_osc;
        wr_reg(8'h05, 8'hFE);
        rd_chk("osc_always", 8'h05, 8'h00);
        wr_reg(8'h05, 8'h01);
        rd_chk("osc_auto", 8'h05, 8'h11);
        ond = 1'b1;
        rd_chk("osc_needed", 8'h05, 8'h01);
        ce = 1'b1;
        rd_chk("osc_emerg", 8'h05, 8'h21);
        chk("standby", {7'h00, stby}, 8'h01);
        {ce, ond} = 2'b00;
        wr_reg(8'h06, 8'hFF);
        rd_chk("unmapped", 8'h06, 8'h00);
        rd_chk("osc_kept", 8'h05, 8'h11);
    endtask
    task automatic t_ramp(input logic [7:0] m);
        wr_reg(8'h03, m | 8'hEE);
        rd_chk("mute_rb", 8'h03, m);
        repeat (3000) @(negedge clk);
        chk("lvol_dn", 8'(lvol inside {[8'hF8:8'hFE]}), {7'h00, m[4]});
        chk("rvol_dn", 8'(rvol inside {[8'hF8:8'hFE]}), {7'h00, m[0]});
        chk("sil_dn", {6'h00, lsil, rsil}, 8'h00);
        wr_reg(8'h03, 8'h00);
        repeat (8000) @(negedge clk);
        chk("lvol_up", lvol, 8'hFF);
        chk("rvol_up", rvol, 8'hFF);
        chk("sil_up", {6'h00, lsil, rsil}, 8'h00);
    endtask
    task automatic t_reset;
        rd_chk("rst_mute", 8'h03, 8'h00);
        rd_chk("rst_pll", 8'h04, 8'h01);
        rd_chk("rst_osc", 8'h05, 8'h11);
        chk("rst_pll_on", {6'h00, pll_on, ext}, 8'h02);
        chk("rst_lvol", lvol, 8'hFF);
        chk("rst_rvol", rvol, 8'hFF);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        {wr, fs, ldi, ldo, av, cp, la, ce, ond, sb} = 10'h000;
        lk = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_status();
        t_pll();
        t_osc();
        t_ramp(8'h10);
        t_ramp(8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
